// ### core/pmic_regs_pkg.sv
/*
	Constants for the power-management status and control register slice:
	register subaddresses, field positions, reset values and state codes.
	Assumes an 8-bit register space reached by subaddress from the serial link.
*/
`default_nettype none

package pmic_regs_pkg;

	// Register width and subaddresses
	localparam int unsigned REG_W = 8;
	localparam logic [7:0] ADDR_PIN_AND_STATE_STATUS = 8'h05;
	localparam logic [7:0] ADDR_CONTROL_BITS = 8'h06;
	localparam logic [7:0] ADDR_SUSPEND_RETENTION_FLAGS = 8'h07;

	// Reset values
	localparam logic [7:0] RST_CONTROL_BITS = 8'h00;
	localparam logic [7:0] RST_SUSPEND_RETENTION_FLAGS = 8'h00;
	localparam logic [7:0] RST_READ_DATA = 8'h00;

	// Status field positions
	localparam int unsigned POS_ADAPTER_PRESENT_STATUS = 5;
	localparam int unsigned POS_BUTTON_PRESSED_STATUS = 4;
	localparam int unsigned POS_STATE_LO = 2;
	localparam int unsigned POS_CELL_LEVEL_LO = 0;

	// Control field positions
	localparam int unsigned POS_POWER_FAIL_SHUTDOWN_ENABLE = 1;
	localparam int unsigned POS_BACKUP_CELL_MEASURE_START = 0;

	// Power state codes as reported
	localparam logic [1:0] STATE_TRANSITIONAL = 2'h0;
	localparam logic [1:0] STATE_WAITING_FOR_POWER_ENABLE = 2'h1;
	localparam logic [1:0] STATE_ACTIVE = 2'h2;
	localparam logic [1:0] STATE_SUSPEND = 2'h3;

	// Level of an inactive active-low pin
	localparam logic PIN_IDLE_LEVEL = 1'b1;

endpackage : pmic_regs_pkg

`default_nettype wire

// ### core/pin_sync.sv
/*
	Two-flop synchroniser for a group of asynchronous pin levels.
	Assumes the pins idle high; the output reads idle during reset.
*/
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
	parameter int unsigned WIDTH = 3
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta;

	// Refused while elaborating, not left to a run
	if (WIDTH < 1)
	begin : g_width_check
		$error("pin_sync WIDTH must be at least 1");
	end

	// First stage feeds only the second
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			meta <= {WIDTH{pmic_regs_pkg::PIN_IDLE_LEVEL}};
			sync_o <= {WIDTH{pmic_regs_pkg::PIN_IDLE_LEVEL}};
		end
		else
		begin
			meta <= async_i;
			sync_o <= meta;
		end
	end

endmodule : pin_sync

`default_nettype wire

// ### core/pmic_status_control_regs.sv
/*
	Status, control and suspend-retention flag registers of the power manager.
	Assumes the serial-link engine presents decoded subaddress accesses on this
	clock, and the power sequencer and coin-cell meter sit on the same clock.
*/
// Contract
// - Adapter status bit reads 1 while adapter pin is low, else 0.
// - Button status bit reads 1 while button pin is low, else 0.
// - State field bits 3-2: 0 transitional, 1 wait, 2 active, 3 suspend.
// - Coin-cell charge level sits in status bits 1-0.
// - Shutdown enable set and comparator low shuts rails off; clear ignores it.
// - Writing 1 starts cell measurement, bit self-clears; writing 0 does nothing.
// - Control at 0x06, resets 0x00, bits 7-2 read zero, bits 1-0 writable.
// - Flag register at 0x07, resets 0x00, all eight bits read-only.
// - Flags show rails kept on in suspend after suspend wake, else 0.
`timescale 1ns/100ps
`default_nettype none

module pmic_status_control_regs (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic SRST_I,
	// Register access
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [7:0] REG_RDATA_O,
	output logic REG_RVALID_O,
	// Pins, active low, asynchronous
	input wire logic ADAPTER_DETECT_INPUT_N_I,
	input wire logic PUSH_BUTTON_INPUT_N_I,
	input wire logic POWER_FAIL_OUTPUT_N_I,
	// Power sequencer
	input wire logic SEQ_WAITING_FOR_POWER_ENABLE_I,
	input wire logic SEQ_ACTIVE_I,
	input wire logic SEQ_SUSPEND_I,
	input wire logic WAKE_FROM_SUSPEND_I,
	input wire logic WAKE_FROM_OFF_I,
	input wire logic [7:0] RAIL_SUSPEND_ENABLE_I,
	output logic SHUTDOWN_REQ_O,
	// Coin-cell meter
	input wire logic CELL_MEASURE_DONE_I,
	input wire logic [1:0] CELL_LEVEL_I,
	output logic BACKUP_CELL_MEASURE_START_O
);

	logic [2:0] pins_sync;
	logic adapter_n;
	logic button_n;
	logic power_fail_n;
	logic power_fail_shutdown_enable;
	logic backup_cell_measure_start;
	logic [1:0] backup_cell_charge_level;
	logic [7:0] suspend_retention_flags;
	logic [1:0] state_code;
	logic [7:0] status_word;
	logic [7:0] control_word;
	logic [7:0] next_rdata;
	logic wr_control;

	function automatic logic [1:0] encode_state(input logic waiting, input logic active,
		input logic suspend);
		logic [1:0] code;
		code = pmic_regs_pkg::STATE_TRANSITIONAL;
		if (waiting && !active && !suspend)
			code = pmic_regs_pkg::STATE_WAITING_FOR_POWER_ENABLE;
		else if (active && !waiting && !suspend)
			code = pmic_regs_pkg::STATE_ACTIVE;
		else if (suspend && !waiting && !active)
			code = pmic_regs_pkg::STATE_SUSPEND;
		return code;
	endfunction : encode_state

	// Pins cross into the register clock before any read sees them
	pin_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.clk_i(CLK_SYS_I),
		.srst_i(SRST_I),
		.async_i({ADAPTER_DETECT_INPUT_N_I, PUSH_BUTTON_INPUT_N_I, POWER_FAIL_OUTPUT_N_I}),
		.sync_o(pins_sync)
	);

	assign adapter_n = pins_sync[2];
	assign button_n = pins_sync[1];
	assign power_fail_n = pins_sync[0];
	assign wr_control = REG_WR_I && (REG_ADDR_I == pmic_regs_pkg::ADDR_CONTROL_BITS);

	// Overlapping sequencer flags count as transitional
	assign state_code = encode_state(SEQ_WAITING_FOR_POWER_ENABLE_I, SEQ_ACTIVE_I,
		SEQ_SUSPEND_I);

	always_comb
	begin
		status_word = 8'h00;
		status_word[pmic_regs_pkg::POS_ADAPTER_PRESENT_STATUS] = !adapter_n;
		status_word[pmic_regs_pkg::POS_BUTTON_PRESSED_STATUS] = !button_n;
		status_word[pmic_regs_pkg::POS_STATE_LO +: 2] = state_code;
		status_word[pmic_regs_pkg::POS_CELL_LEVEL_LO +: 2] = backup_cell_charge_level;
	end

	always_comb
	begin
		control_word = 8'h00;
		control_word[pmic_regs_pkg::POS_POWER_FAIL_SHUTDOWN_ENABLE] = power_fail_shutdown_enable;
		control_word[pmic_regs_pkg::POS_BACKUP_CELL_MEASURE_START] = backup_cell_measure_start;
	end

	// Power-fail shutdown enable, plain read/write
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
			power_fail_shutdown_enable <=
				pmic_regs_pkg::RST_CONTROL_BITS[pmic_regs_pkg::POS_POWER_FAIL_SHUTDOWN_ENABLE];
		else if (wr_control)
			power_fail_shutdown_enable <=
				REG_WDATA_I[pmic_regs_pkg::POS_POWER_FAIL_SHUTDOWN_ENABLE];
	end

	// Measurement start: a new write of 1 wins over the meter's done
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
			backup_cell_measure_start <=
				pmic_regs_pkg::RST_CONTROL_BITS[pmic_regs_pkg::POS_BACKUP_CELL_MEASURE_START];
		else if (wr_control && REG_WDATA_I[pmic_regs_pkg::POS_BACKUP_CELL_MEASURE_START])
			backup_cell_measure_start <= 1'b1;
		else if (CELL_MEASURE_DONE_I)
			backup_cell_measure_start <= 1'b0;
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
			BACKUP_CELL_MEASURE_START_O <= 1'b0;
		else if (wr_control && REG_WDATA_I[pmic_regs_pkg::POS_BACKUP_CELL_MEASURE_START])
			BACKUP_CELL_MEASURE_START_O <= 1'b1;
		else if (CELL_MEASURE_DONE_I)
			BACKUP_CELL_MEASURE_START_O <= 1'b0;
	end

	// Level is meaningless until the first measurement completes
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
			backup_cell_charge_level <= 2'h0;
		else if (CELL_MEASURE_DONE_I)
			backup_cell_charge_level <= CELL_LEVEL_I;
	end

	// Registered each cycle from the enable and the pin, not held; a short dip gives a short request
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
			SHUTDOWN_REQ_O <= 1'b0;
		else
			SHUTDOWN_REQ_O <= power_fail_shutdown_enable && !power_fail_n;
	end

	// Flags change only on wake; register writes never reach them
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
			suspend_retention_flags <= pmic_regs_pkg::RST_SUSPEND_RETENTION_FLAGS;
		else if (WAKE_FROM_OFF_I)
			suspend_retention_flags <= 8'h00;
		else if (WAKE_FROM_SUSPEND_I)
			suspend_retention_flags <= RAIL_SUSPEND_ENABLE_I;
	end

	always_comb
	begin
		unique case (REG_ADDR_I)
			pmic_regs_pkg::ADDR_PIN_AND_STATE_STATUS: next_rdata = status_word;
			pmic_regs_pkg::ADDR_CONTROL_BITS: next_rdata = control_word;
			pmic_regs_pkg::ADDR_SUSPEND_RETENTION_FLAGS: next_rdata = suspend_retention_flags;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (SRST_I)
		begin
			REG_RDATA_O <= pmic_regs_pkg::RST_READ_DATA;
			REG_RVALID_O <= 1'b0;
		end
		else
		begin
			REG_RVALID_O <= REG_RD_I;
			if (REG_RD_I)
				REG_RDATA_O <= next_rdata;
		end
	end

	a_adapter_level: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		REG_RD_I && REG_ADDR_I == pmic_regs_pkg::ADDR_PIN_AND_STATE_STATUS
		|=> REG_RDATA_O[5] == !$past(adapter_n))
		else $error("adapter status does not follow pin");

	a_button_level: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		REG_RD_I && REG_ADDR_I == pmic_regs_pkg::ADDR_PIN_AND_STATE_STATUS
		|=> REG_RDATA_O[4] == !$past(button_n))
		else $error("button status does not follow pin");

	a_state_active: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		REG_RD_I && REG_ADDR_I == pmic_regs_pkg::ADDR_PIN_AND_STATE_STATUS
		&& SEQ_ACTIVE_I && !SEQ_SUSPEND_I && !SEQ_WAITING_FOR_POWER_ENABLE_I
		|=> REG_RDATA_O[3:2] == 2'h2)
		else $error("active state not reported as 2");

	a_cell_level: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		CELL_MEASURE_DONE_I |=> backup_cell_charge_level == $past(CELL_LEVEL_I))
		else $error("charge level not captured on done");

	a_pf_shutdown: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		!SHUTDOWN_REQ_O ##1 (power_fail_shutdown_enable && !power_fail_n) |=> SHUTDOWN_REQ_O)
		else $error("power fail did not request shutdown");

	a_pf_ignored: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		!power_fail_shutdown_enable |=> !SHUTDOWN_REQ_O)
		else $error("shutdown requested while disabled");

	a_measure_cycle: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		wr_control && REG_WDATA_I[0] |=> BACKUP_CELL_MEASURE_START_O && backup_cell_measure_start)
		else $error("measure start bit not set by write");

	a_measure_clear: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		CELL_MEASURE_DONE_I && !(wr_control && REG_WDATA_I[0])
		|=> !BACKUP_CELL_MEASURE_START_O && !backup_cell_measure_start)
		else $error("measure start bit did not self-clear");

	a_measure_write0: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		wr_control && !REG_WDATA_I[0] && !CELL_MEASURE_DONE_I
		|=> backup_cell_measure_start == $past(backup_cell_measure_start))
		else $error("writing zero changed measure start");

	a_ctrl_reserved: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		REG_RD_I && REG_ADDR_I == pmic_regs_pkg::ADDR_CONTROL_BITS |=> REG_RDATA_O[7:2] == 6'h00)
		else $error("control reserved bits not zero");

	a_flag_readonly: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		!WAKE_FROM_OFF_I && !WAKE_FROM_SUSPEND_I |=> $stable(suspend_retention_flags))
		else $error("flags changed without wake");

	a_flag_wake: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		WAKE_FROM_SUSPEND_I && !WAKE_FROM_OFF_I
		|=> suspend_retention_flags == $past(RAIL_SUSPEND_ENABLE_I))
		else $error("flags do not match suspend enables");

	a_flag_off: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
		WAKE_FROM_OFF_I |=> suspend_retention_flags == 8'h00)
		else $error("flags not cleared on wake from off");

endmodule : pmic_status_control_regs

`default_nettype wire

// ### test/cell_meter_model.sv
/*
	Coin-cell meter model: answers a start level with a one-cycle done pulse.
	Assumes start comes from the register slice on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module cell_meter_model (
	// Clock
	input wire logic clk_i,
	// Request and answer
	input wire logic start_i,
	output logic done_o,
	output logic [1:0] level_o
);
	int cnt = 0;

	initial done_o = 1'b0;
	initial level_o = 2'h0;

	// Level is junk outside done, so a late capture shows up
	always @(posedge clk_i)
	begin
		if (start_i && !done_o && cnt == 1)
		begin
			cnt <= 0;
			done_o <= 1'b1;
			level_o <= 2'($urandom);
		end
		else
		begin
			done_o <= 1'b0;
			level_o <= ~level_o;
			if (start_i && !done_o)
				cnt <= (cnt == 0) ? 1 + int'($urandom_range(0, 9)) : cnt - 1;
		end
	end
endmodule : cell_meter_model

`default_nettype wire

// ### test/tb.sv
/*
	Self-checking bench of the status, control and flag registers.
	Assumes decoded one-cycle strobes and a meter model on the far side.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rails = 8'h00, rdata, got;
	logic wr = 1'b0, rd = 1'b0, ac_n = 1'b1, btn_n = 1'b1, pf_n = 1'b1;
	logic wk_s = 1'b0, wk_o = 1'b0, rvalid, shut, start, done;
	logic [2:0] seq = 3'h0, rnd_seq;
	logic [1:0] lvl, exp_lvl = 2'h0;
	int fails = 0, comparisons = 0, i;

	initial forever #2.5 clk = ~clk;

	pmic_status_control_regs dut (.CLK_SYS_I(clk), .SRST_I(rst), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
		.REG_RVALID_O(rvalid), .ADAPTER_DETECT_INPUT_N_I(ac_n), .PUSH_BUTTON_INPUT_N_I(btn_n),
		.POWER_FAIL_OUTPUT_N_I(pf_n), .SEQ_WAITING_FOR_POWER_ENABLE_I(seq[0]),
		.SEQ_ACTIVE_I(seq[1]), .SEQ_SUSPEND_I(seq[2]), .WAKE_FROM_SUSPEND_I(wk_s),
		.WAKE_FROM_OFF_I(wk_o), .RAIL_SUSPEND_ENABLE_I(rails), .SHUTDOWN_REQ_O(shut),
		.CELL_MEASURE_DONE_I(done), .CELL_LEVEL_I(lvl), .BACKUP_CELL_MEASURE_START_O(start));

	cell_meter_model meter (.clk_i(clk), .start_i(start), .done_o(done), .level_o(lvl));

	// Level is only good in the done cycle
	always @(posedge clk)
		if (done === 1'b1)
			exp_lvl <= lvl;

	function automatic logic [1:0] exp_state(input logic [2:0] s);
		case (s)
			3'h1: return pmic_regs_pkg::STATE_WAITING_FOR_POWER_ENABLE;
			3'h2: return pmic_regs_pkg::STATE_ACTIVE;
			3'h4: return pmic_regs_pkg::STATE_SUSPEND;
			default: return pmic_regs_pkg::STATE_TRANSITIONAL;
		endcase
	endfunction : exp_state

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 wr = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1 wr = 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		#1 rd = 1'b1;
		addr = a;
		@(posedge clk);
		#1 rd = 1'b0;
		got = rdata;
		chk({7'h00, rvalid}, 8'h01);
	endtask : rd_reg

	task automatic end_sim;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	initial
	begin
		#100000;
		fails++;
		end_sim();
	end

	initial
	begin
		void'($urandom(66));
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		rd_reg(pmic_regs_pkg::ADDR_CONTROL_BITS);
		chk(got, pmic_regs_pkg::RST_CONTROL_BITS);
		rd_reg(pmic_regs_pkg::ADDR_SUSPEND_RETENTION_FLAGS);
		chk(got, pmic_regs_pkg::RST_SUSPEND_RETENTION_FLAGS);
		rd_reg(8'h20);
		chk(got, 8'h00);
		// Reserved and read-only bits must shrug off writes
		wr_reg(pmic_regs_pkg::ADDR_CONTROL_BITS, 8'hFE);
		rd_reg(pmic_regs_pkg::ADDR_CONTROL_BITS);
		chk(got, 8'h02);
		wr_reg(pmic_regs_pkg::ADDR_SUSPEND_RETENTION_FLAGS, 8'hFF);
		rd_reg(pmic_regs_pkg::ADDR_SUSPEND_RETENTION_FLAGS);
		chk(got, 8'h00);
		pf_n = 1'b0;
		repeat (4) @(posedge clk);
		#1 chk({7'h00, shut}, 8'h01);
		wr_reg(pmic_regs_pkg::ADDR_CONTROL_BITS, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk({6'h00, shut, start}, 8'h00);
		pf_n = 1'b1;
		// Trigger a measurement before trusting the level
		repeat (4)
		begin
			wr_reg(pmic_regs_pkg::ADDR_CONTROL_BITS, 8'h01);
			chk({7'h00, start}, 8'h01);
			// Done comes two edges after the write at the earliest, so zero cannot race it
			wr_reg(pmic_regs_pkg::ADDR_CONTROL_BITS, 8'h00);
			chk({7'h00, start}, 8'h01);
			for (i = 0; i < 40 && start !== 1'b0; i++)
			begin
				@(posedge clk);
				#1;
			end
			#1 rd_reg(pmic_regs_pkg::ADDR_CONTROL_BITS);
			chk(got, 8'h00);
			rd_reg(pmic_regs_pkg::ADDR_PIN_AND_STATE_STATUS);
			chk({6'h00, got[1:0]}, {6'h00, exp_lvl});
		end
		// Every state code first, then random pins and states
		for (i = 0; i < 24; i++)
		begin
			{ac_n, btn_n, rnd_seq} = 5'($urandom);
			seq = (i < 8) ? 3'(i) : rnd_seq;
			repeat (3) @(posedge clk);
			#1 rd_reg(pmic_regs_pkg::ADDR_PIN_AND_STATE_STATUS);
			chk(got, {2'h0, ~ac_n, ~btn_n, exp_state(seq), exp_lvl});
		end
		rails = 8'($urandom);
		wk_s = 1'b1;
		@(posedge clk);
		#1 wk_s = 1'b0;
		rd_reg(pmic_regs_pkg::ADDR_SUSPEND_RETENTION_FLAGS);
		chk(got, rails);
		// Wake from off wins over a coincident suspend wake
		wk_s = 1'b1;
		wk_o = 1'b1;
		@(posedge clk);
		#1 wk_s = 1'b0;
		wk_o = 1'b0;
		rd_reg(pmic_regs_pkg::ADDR_SUSPEND_RETENTION_FLAGS);
		chk(got, 8'h00);
		// Reset in mid-run must drop a written control word
		wr_reg(pmic_regs_pkg::ADDR_CONTROL_BITS, 8'h02);
		#1 rst = 1'b1;
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		chk({5'h00, shut, start, rvalid}, 8'h00);
		rd_reg(pmic_regs_pkg::ADDR_CONTROL_BITS);
		chk(got, pmic_regs_pkg::RST_CONTROL_BITS);
		end_sim();
	end
endmodule : tb

`default_nettype wire
